// file: shared/tmr4_pkg.sv
// Constants, mode codes and carrier structs for the timer 4 block.
// Assumes one 250 MHz system clock and a synchronous active-low reset.
package tmr4_pkg;

    // ------------------------------------------------------------------
    // Mode codes, ordered {mode_bit1, capture_reload_sel, mode_bit0}
    // ------------------------------------------------------------------
    localparam logic [2:0] MODE_RELOAD_EXT = 3'h0;
    localparam logic [2:0] MODE_RELOAD = 3'h1;
    localparam logic [2:0] MODE_CAPTURE = 3'h2;
    localparam logic [2:0] MODE_CAPTURE_ZERO = 3'h3;
    localparam logic [2:0] MODE_PWM = 3'h4;
    localparam logic [2:0] MODE_DUTY = 3'h6;

    // ------------------------------------------------------------------
    // Clock source codes
    // ------------------------------------------------------------------
    localparam logic [2:0] HSRC_DIV12 = 3'h0;
    localparam logic [2:0] HSRC_PIN = 3'h1;
    localparam logic [2:0] HSRC_SYSCLK = 3'h2;
    localparam logic [2:0] HSRC_CHAIN = 3'h3;
    localparam logic [2:0] HSRC_TMR0 = 3'h5;
    localparam logic [2:0] HSRC_CMP2 = 3'h6;
    localparam logic [2:0] HSRC_CMP0 = 3'h7;
    localparam logic [1:0] LSRC_DIV12 = 2'h0;
    localparam logic [1:0] LSRC_SYSCLK = 2'h1;
    localparam logic [1:0] LSRC_EXT = 2'h3;

    // ------------------------------------------------------------------
    // Counts and reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] PRESCALE_LAST = 4'hb;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hff;
    localparam int SYNC_WIDTH = 2;
    localparam int PIN_TRIGGER = 0;
    localparam int PIN_COUNT = 1;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic split_enable;
        logic mode_bit1;
        logic capture_reload_sel;
        logic mode_bit0;
        logic fall_edge_en;
        logic rise_edge_en;
        logic low_run_autoclear;
        logic clkout_enable;
        logic ovf_irq_ignore;
        logic low_ovf_irq_en;
        logic bit6_access_select;
        logic [2:0] high_clk_sel;
        logic low_clk_sel;
    } tmr4_cfg_s;

    typedef struct packed {
        logic we_count_high;
        logic we_count_low;
        logic we_capture_high;
        logic we_capture_low;
        logic we_run;
        logic we_low_run;
        logic we_bit6;
        logic clr_ovf;
        logic clr_ext;
        logic clr_low_ovf;
        logic [7:0] wdata;
    } tmr4_sw_s;

    typedef struct packed {
        logic chain_in;
        logic tmr0_ovf;
        logic cmp2_event;
        logic cmp0_event;
    } tmr4_src_s;

    typedef enum logic [1:0] {
        DUTY_IDLE,
        DUTY_ARMED,
        DUTY_FIRST,
        DUTY_SECOND
    } tmr4_duty_e;

endpackage : tmr4_pkg

// file: verification/tmr4_assertions.sv
// Port-level checks of the timer 4 core.
// Assumes it is bound onto every tmr4_core instance.
`timescale 1ns/1ns
module tmr4_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire tmr4_pkg::tmr4_cfg_s cfg,
    input wire tmr4_pkg::tmr4_sw_s sw,
    input wire logic [7:0] count_high,
    input wire logic [7:0] count_low,
    input wire logic ovf_flag,
    input wire logic ext_event_flag,
    input wire logic low_ovf_flag,
    input wire logic timer_irq,
    input wire logic overflow_event,
    input wire logic ext_event_set,
    input wire logic clock_out_pin
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    ovf_sticky_a: assert property (
        ovf_flag && !sw.clr_ovf |=> ovf_flag) else $error("overflow flag lost");
    ext_sticky_a: assert property (
        ext_event_flag && !sw.clr_ext |=> ext_event_flag) else $error("event flag lost");
    irq_map_a: assert property (timer_irq == (ext_event_flag
        || ovf_flag && !$past(cfg.ovf_irq_ignore) || low_ovf_flag && $past(cfg.low_ovf_irq_en)))
        else $error("interrupt mismatch");
    pin_gate_a: assert property (
        !cfg.clkout_enable [*3] |-> !clock_out_pin) else $error("pin not gated");
    reserved_hold_a: assert property ((
        !cfg.split_enable && {cfg.mode_bit1, cfg.capture_reload_sel, cfg.mode_bit0} == 3'h7
        && !sw.we_count_high && !sw.we_count_low) [*2]
        |-> $stable({count_high, count_low}) && !$rose(ovf_flag)) else $error("reserved ran");
    zero_capture_a: assert property ($rose(ext_event_flag) && !$past(cfg.split_enable)
        && $past({cfg.mode_bit1, cfg.capture_reload_sel, cfg.mode_bit0}) == 3'h3
        && !$past(sw.we_count_high) |-> count_high == 8'h00) else $error("count not zeroed");
    split_event_a: assert property (
        $rose(low_ovf_flag) && $past(cfg.split_enable) |-> overflow_event)
        else $error("no low overflow event");
    event_16_a: assert property (
        $rose(ovf_flag) && !$past(cfg.split_enable) |-> overflow_event)
        else $error("no overflow event");
    split_clk_a: assert property ($past(cfg.split_enable && cfg.clkout_enable
        && !cfg.capture_reload_sel && !cfg.mode_bit1) |-> !$rose(low_ovf_flag))
        else $error("low flag in clock out");
    ext_set_a: assert property ($rose(ext_event_flag) |-> ext_event_set)
        else $error("no event pulse");
endmodule : tmr4_chk
bind tmr4_core tmr4_chk chk (.clk, .rstn, .cfg, .sw, .count_high, .count_low, .ovf_flag,
    .ext_event_flag, .low_ovf_flag, .timer_irq, .overflow_event, .ext_event_set,
    .clock_out_pin);

// file: verification/tmr4_core_bench.sv
// Self-checking bench for the timer 4 core.
// Assumes the checker is bound onto the core and the far model drives the trigger.
`timescale 1ns/1ns
module tmr4_core_bench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    tmr4_pkg::tmr4_cfg_s cfg = '0;
    tmr4_pkg::tmr4_sw_s sw = '0;
    tmr4_pkg::tmr4_src_s src = '0;
    logic cpin = 1'b1;
    logic trg;
    logic [7:0] count_high, count_low, capture_high, capture_low;
    logic run_bit, low_run_bit, low_clock_mult, trigger_invert, ovf_flag;
    logic ext_event_flag, low_ovf_flag, timer_irq, clock_out_pin, overflow_event, ext_event_set;
    int bad_count = 0;
    int check_count = 0;
    int t = 0;
    always #2 clk = ~clk;
    tmr4_far far (.trigger_input(trg));
    tmr4_core dut (.clk, .rstn, .cfg, .sw, .src, .trigger_input(trg), .count_pin(cpin),
        .count_high, .count_low, .capture_high, .capture_low, .run_bit, .low_run_bit,
        .low_clock_mult, .trigger_invert, .ovf_flag, .ext_event_flag, .low_ovf_flag,
        .timer_irq, .overflow_event, .ext_event_set, .clock_out_pin);
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value at %0t: %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic bit1(input logic s, input logic e);
        chk({15'h0, s}, {15'h0, e});
    endtask : bit1
    task automatic wr(input logic [9:0] m, input logic [7:0] d);
        @(negedge clk);
        sw = {m, d};
        @(negedge clk);
        sw = '0;
    endtask : wr
    task automatic wf(ref logic f, input logic v);
        int i;
        for (i = 0; i < 4000 && f !== v; i++) @(negedge clk);
        if (f !== v) begin
            bad_count++;
            results();
        end
    endtask : wf
    // Measures the first whole interval between clock-out changes.
    task automatic gap(input int e);
        int n;
        logic p;
        repeat (2) begin
            p = clock_out_pin;
            n = 0;
            while (clock_out_pin === p && n < 999) begin
                @(negedge clk);
                n++;
            end
        end
        chk(16'(n), 16'(e));
    endtask : gap
    task automatic nx;
        t++;
        $display("test %0d done", t);
    endtask : nx
    initial begin
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        cfg.mode_bit0 = 1'b1;
        cfg.high_clk_sel = 3'h2;
        cfg.clkout_enable = 1'b1;
        wr(10'h280, 8'hff);
        wr(10'h140, 8'hf0);
        wr(10'h020, 8'h01);
        gap(16);
        wf(ovf_flag, 1'b1);
        bit1(timer_irq, 1'b1);
        cfg.ovf_irq_ignore = 1'b1;
        wr(10'h004, 8'h00);
        wf(ovf_flag, 1'b1);
        bit1(timer_irq, 1'b0);
        nx();
        wr(10'h027, 8'h00);
        cfg.clkout_enable = 1'b0;
        cfg.split_enable = 1'b1;
        cfg.mode_bit0 = 1'b0;
        cfg.low_ovf_irq_en = 1'b1;
        wr(10'h008, 8'h01);
        bit1(low_clock_mult, 1'b1);
        cfg.bit6_access_select = 1'b1;
        wr(10'h008, 8'h01);
        chk({14'h0, trigger_invert, low_clock_mult}, 16'h0003);
        wr(10'h008, 8'h00);
        cfg.bit6_access_select = 1'b0;
        wr(10'h140, 8'hf0);
        wr(10'h010, 8'h01);
        wf(low_ovf_flag, 1'b1);
        bit1(timer_irq, 1'b1);
        cfg.low_run_autoclear = 1'b1;
        wr(10'h280, 8'hfe);
        wr(10'h020, 8'h01);
        wf(ovf_flag, 1'b1);
        wf(low_run_bit, 1'b0);
        bit1(low_ovf_flag, 1'b1);
        nx();
        cfg.low_run_autoclear = 1'b0;
        wr(10'h020, 8'h00);
        cfg.clkout_enable = 1'b1;
        wr(10'h011, 8'h01);
        gap(16);
        bit1(low_ovf_flag, 1'b0);
        wr(10'h010, 8'h00);
        cfg.mode_bit1 = 1'b1;
        wr(10'h040, 8'hf8);
        wr(10'h280, 8'hf0);
        wr(10'h024, 8'h01);
        wf(ovf_flag, 1'b1);
        chk({8'h0, count_low}, 16'h00f8);
        gap(8);
        nx();
        wr(10'h020, 8'h00);
        cfg = '0;
        cfg.high_clk_sel = 3'h2;
        cfg.capture_reload_sel = 1'b1;
        cfg.mode_bit0 = 1'b1;
        cfg.fall_edge_en = 1'b1;
        wr(10'h302, 8'h00);
        wr(10'h020, 8'h01);
        far.drive(1'b1);
        repeat (300) @(negedge clk);
        far.drive(1'b0);
        bit1(ext_event_flag, 1'b1);
        chk({count_high, capture_high}, 16'h0001);
        nx();
        wr(10'h020, 8'h00);
        cfg.mode_bit1 = 1'b1;
        cfg.mode_bit0 = 1'b0;
        cfg.rise_edge_en = 1'b1;
        wr(10'h302, 8'h00);
        wr(10'h020, 8'h01);
        far.drive(1'b0);
        chk({count_high, count_low}, 16'h0000);
        far.drive(1'b1);
        bit1(ext_event_flag, 1'b0);
        far.drive(1'b0);
        bit1(ext_event_flag, 1'b1);
        chk({capture_high, capture_low}, 16'h0009);
        far.drive(1'b1);
        wf(run_bit, 1'b0);
        nx();
        cfg.mode_bit0 = 1'b1;
        wr(10'h300, 8'hff);
        wr(10'h026, 8'h01);
        far.drive(1'b0);
        chk({count_high, count_low}, 16'hffff);
        chk({12'h0, ovf_flag, ext_event_flag, overflow_event, ext_event_set}, 16'h0000);
        nx();
        cfg.high_clk_sel = 3'h1;
        cfg.low_clk_sel = 1'b1;
        cfg.split_enable = 1'b1;
        cfg.mode_bit1 = 1'b0;
        wr(10'h300, 8'h00);
        wr(10'h010, 8'h01);
        repeat (3) begin
            cpin = 1'b0;
            src.chain_in = 1'b1;
            @(negedge clk);
            src.chain_in = 1'b0;
            repeat (4) @(negedge clk);
            cpin = 1'b1;
            repeat (4) @(negedge clk);
        end
        chk({count_high, count_low}, 16'h0303);
        nx();
        results();
    end
endmodule : tmr4_core_bench

// file: verification/tmr4_far.sv
// Far-side model of the timer's trigger pin.
// Assumes the bench calls drive just after a falling clock edge.
`timescale 1ns/1ns
module tmr4_far (
    output logic trigger_input
);
    // The pin rests low, so the first edge of a duty capture rises.
    initial trigger_input = 1'b0;
    task automatic drive(input logic v);
        trigger_input = v;
        #40;
    endtask : drive
endmodule : tmr4_far

// file: verilog/tmr4_core.sv
// Timer 4 core: 16-bit and split 8-bit counting, capture, duty capture,
// 8-bit PWM and 50% clock output.
// Assumes software control arrives as same-clock strobes and level bits.
`timescale 1ns/1ns

module tmr4_core (
    input wire logic clk,
    input wire logic rstn,
    input wire tmr4_pkg::tmr4_cfg_s cfg,
    input wire tmr4_pkg::tmr4_sw_s sw,
    input wire tmr4_pkg::tmr4_src_s src,
    input wire logic trigger_input,
    input wire logic count_pin,
    output logic [7:0] count_high,
    output logic [7:0] count_low,
    output logic [7:0] capture_high,
    output logic [7:0] capture_low,
    output logic run_bit,
    output logic low_run_bit,
    output logic low_clock_mult,
    output logic trigger_invert,
    output logic ovf_flag,
    output logic ext_event_flag,
    output logic low_ovf_flag,
    output logic timer_irq,
    output logic overflow_event,
    output logic ext_event_set,
    output logic clock_out_pin
);

    // ------------------------------------------------------------------
    // Pin synchronisation and count ticks
    // ------------------------------------------------------------------
    logic [tmr4_pkg::SYNC_WIDTH-1:0] pin_rise, pin_fall;
    logic tick_high, tick_low, low_ovf;

    tmr4_sync u_sync (
        .clk(clk),
        .rstn(rstn),
        .pin_async({count_pin, trigger_input}),
        .pin_rise(pin_rise),
        .pin_fall(pin_fall)
    );

    tmr4_tick u_tick (
        .clk(clk),
        .rstn(rstn),
        .split(cfg.split_enable),
        .high_sel(cfg.high_clk_sel),
        .low_sel({cfg.low_clk_sel, low_clock_mult}),
        .pin_tick(pin_fall[tmr4_pkg::PIN_COUNT]),
        .low_ovf(low_ovf),
        .src(src),
        .tick_high(tick_high),
        .tick_low(tick_low)
    );

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    function automatic logic mode_legal(input logic [2:0] m, input logic split);
        if (split) begin
            mode_legal = (m == tmr4_pkg::MODE_PWM) || !m[2];
        end else begin
            mode_legal = (m == tmr4_pkg::MODE_DUTY) || !m[2];
        end
    endfunction : mode_legal

    logic [2:0] mode;
    logic legal, is_pwm, is_duty, trig_rise, trig_fall, trig_edge, ext_evt, clkout_reload;

    assign mode = {cfg.mode_bit1, cfg.capture_reload_sel, cfg.mode_bit0};
    assign legal = mode_legal(mode, cfg.split_enable);
    assign is_pwm = cfg.split_enable && (mode == tmr4_pkg::MODE_PWM);
    assign is_duty = !cfg.split_enable && (mode == tmr4_pkg::MODE_DUTY);
    // Inversion swaps which physical edge counts as rising.
    assign trig_rise = trigger_invert ? pin_fall[tmr4_pkg::PIN_TRIGGER]
                                      : pin_rise[tmr4_pkg::PIN_TRIGGER];
    assign trig_fall = trigger_invert ? pin_rise[tmr4_pkg::PIN_TRIGGER]
                                      : pin_fall[tmr4_pkg::PIN_TRIGGER];
    assign trig_edge = trig_rise | trig_fall;
    assign ext_evt = legal && !is_duty
        && ((trig_fall && cfg.fall_edge_en) || (trig_rise && cfg.rise_edge_en));
    assign clkout_reload = cfg.clkout_enable && !cfg.capture_reload_sel && !is_pwm;

    // ------------------------------------------------------------------
    // Counter, capture, duty sequencing and flags
    // ------------------------------------------------------------------
    tmr4_pkg::tmr4_duty_e duty_st, next_duty_st;
    logic [7:0] next_count_high, next_count_low, next_capture_high, next_capture_low;
    logic next_run_bit, next_low_run_bit, next_low_clock_mult, next_trigger_invert;
    logic next_ovf_flag, next_ext_event_flag, next_low_ovf_flag, next_timer_irq;
    logic next_overflow_event, next_ext_event_set, next_clock_out_pin;
    logic set_ovf, set_ext, set_low;
    logic inc16, ovf16, inc_h, ovf_h, inc_l;
    logic [15:0] count_sum;

    assign count_sum = {count_high, count_low} + 16'h0001;
    assign inc16 = !cfg.split_enable && legal && run_bit && tick_high
        && (!is_duty || duty_st == tmr4_pkg::DUTY_FIRST
            || duty_st == tmr4_pkg::DUTY_SECOND);
    assign ovf16 = inc16 && ({count_high, count_low} == 16'hffff);
    assign inc_h = cfg.split_enable && legal && run_bit && tick_high;
    assign ovf_h = inc_h && (count_high == tmr4_pkg::BYTE_MAX);
    assign inc_l = cfg.split_enable && legal && !is_pwm && low_run_bit && tick_low;
    assign low_ovf = inc_l && (count_low == tmr4_pkg::BYTE_MAX);

    always_comb begin
        next_count_high = count_high;
        next_count_low = count_low;
        next_capture_high = capture_high;
        next_capture_low = capture_low;
        next_run_bit = run_bit;
        next_low_run_bit = low_run_bit;
        next_low_clock_mult = low_clock_mult;
        next_trigger_invert = trigger_invert;
        next_duty_st = duty_st;
        set_ovf = 1'b0;
        set_ext = 1'b0;
        set_low = 1'b0;
        next_clock_out_pin = clock_out_pin;

        if (!cfg.split_enable) begin
            if (inc16) begin
                {next_count_high, next_count_low} = count_sum;
            end
            if (ovf16) begin
                set_ovf = 1'b1;
                if (!cfg.capture_reload_sel) begin
                    {next_count_high, next_count_low} = {capture_high, capture_low};
                end
            end
            if (ext_evt) begin
                set_ext = 1'b1;
                case (mode)
                    tmr4_pkg::MODE_RELOAD: begin
                        {next_count_high, next_count_low} = {capture_high, capture_low};
                    end
                    tmr4_pkg::MODE_CAPTURE: begin
                        {next_capture_high, next_capture_low} = {count_high, count_low};
                    end
                    tmr4_pkg::MODE_CAPTURE_ZERO: begin
                        {next_capture_high, next_capture_low} = {count_high, count_low};
                        next_count_high = tmr4_pkg::BYTE_RESET;
                        next_count_low = tmr4_pkg::BYTE_RESET;
                    end
                    default: ;
                endcase
            end
            if (clkout_reload && ovf16) begin
                next_clock_out_pin = !clock_out_pin;
            end
        end else begin
            if (inc_l) begin
                next_count_low = low_ovf ? capture_low : count_low + 8'h01;
            end
            if (low_ovf && !clkout_reload) begin
                set_low = 1'b1;
            end
            if (clkout_reload && low_ovf) begin
                next_clock_out_pin = !clock_out_pin;
            end
            if (inc_h) begin
                next_count_high = count_high + 8'h01;
            end
            if (ovf_h) begin
                set_ovf = 1'b1;
                next_count_high = cfg.capture_reload_sel ? tmr4_pkg::BYTE_RESET
                                                         : capture_high;
                if (is_pwm) begin
                    next_count_low = capture_low;
                end
                if (cfg.low_run_autoclear && !cfg.capture_reload_sel) begin
                    next_low_run_bit = 1'b0;
                end
            end
            if (ext_evt) begin
                set_ext = 1'b1;
                case (mode)
                    tmr4_pkg::MODE_RELOAD: begin
                        next_count_high = capture_high;
                    end
                    tmr4_pkg::MODE_CAPTURE: begin
                        {next_capture_high, next_capture_low} = {count_high, count_low};
                    end
                    tmr4_pkg::MODE_CAPTURE_ZERO: begin
                        {next_capture_high, next_capture_low} = {count_high, count_low};
                        next_count_high = tmr4_pkg::BYTE_RESET;
                    end
                    default: ;
                endcase
                if (cfg.low_run_autoclear && cfg.capture_reload_sel) begin
                    next_low_run_bit = 1'b0;
                end
            end
            if (is_pwm) begin
                next_clock_out_pin = cfg.clkout_enable
                    && (count_high < count_low);
            end
        end

        case (duty_st)
            tmr4_pkg::DUTY_IDLE: begin
                if (is_duty && run_bit) begin
                    next_duty_st = tmr4_pkg::DUTY_ARMED;
                end
            end
            tmr4_pkg::DUTY_ARMED: begin
                if (trig_rise) begin
                    next_duty_st = tmr4_pkg::DUTY_FIRST;
                end
            end
            tmr4_pkg::DUTY_FIRST: begin
                if (trig_edge) begin
                    next_duty_st = tmr4_pkg::DUTY_SECOND;
                    if (cfg.fall_edge_en) begin
                        {next_capture_high, next_capture_low} = {count_high, count_low};
                        set_ext = 1'b1;
                    end
                end
            end
            tmr4_pkg::DUTY_SECOND: begin
                if (trig_edge) begin
                    next_duty_st = tmr4_pkg::DUTY_IDLE;
                    next_run_bit = 1'b0;
                end
            end
            default: begin
                next_duty_st = tmr4_pkg::DUTY_IDLE;
            end
        endcase
        if (!is_duty || !run_bit) begin
            next_duty_st = tmr4_pkg::DUTY_IDLE;
        end

        if (!cfg.clkout_enable) begin
            next_clock_out_pin = 1'b0;
        end

        // Software writes take the register over any hardware update.
        next_count_high = sw.we_count_high ? sw.wdata : next_count_high;
        next_count_low = sw.we_count_low ? sw.wdata : next_count_low;
        next_capture_high = sw.we_capture_high ? sw.wdata : next_capture_high;
        next_capture_low = sw.we_capture_low ? sw.wdata : next_capture_low;
        if (sw.we_run) begin
            next_run_bit = sw.wdata[0];
        end
        if (sw.we_low_run) begin
            next_low_run_bit = sw.wdata[0];
        end
        if (sw.we_bit6) begin
            if (cfg.bit6_access_select) begin
                next_trigger_invert = sw.wdata[0];
            end else begin
                next_low_clock_mult = sw.wdata[0];
            end
        end

        // A hardware set in the clearing cycle wins.
        next_ovf_flag = set_ovf || (ovf_flag && !sw.clr_ovf);
        next_ext_event_flag = set_ext || (ext_event_flag && !sw.clr_ext);
        next_low_ovf_flag = set_low || (low_ovf_flag && !sw.clr_low_ovf);
        next_timer_irq = next_ext_event_flag
            || (next_ovf_flag && !cfg.ovf_irq_ignore)
            || (next_low_ovf_flag && cfg.low_ovf_irq_en);
        next_overflow_event = cfg.split_enable ? low_ovf : ovf16;
        next_ext_event_set = set_ext;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            count_high <= tmr4_pkg::BYTE_RESET;
            count_low <= tmr4_pkg::BYTE_RESET;
            capture_high <= tmr4_pkg::BYTE_RESET;
            capture_low <= tmr4_pkg::BYTE_RESET;
            run_bit <= 1'b0;
            low_run_bit <= 1'b0;
            low_clock_mult <= 1'b0;
            trigger_invert <= 1'b0;
            duty_st <= tmr4_pkg::DUTY_IDLE;
            ovf_flag <= 1'b0;
            ext_event_flag <= 1'b0;
            low_ovf_flag <= 1'b0;
            timer_irq <= 1'b0;
            overflow_event <= 1'b0;
            ext_event_set <= 1'b0;
            clock_out_pin <= 1'b0;
        end else begin
            count_high <= next_count_high;
            count_low <= next_count_low;
            capture_high <= next_capture_high;
            capture_low <= next_capture_low;
            run_bit <= next_run_bit;
            low_run_bit <= next_low_run_bit;
            low_clock_mult <= next_low_clock_mult;
            trigger_invert <= next_trigger_invert;
            duty_st <= next_duty_st;
            ovf_flag <= next_ovf_flag;
            ext_event_flag <= next_ext_event_flag;
            low_ovf_flag <= next_low_ovf_flag;
            timer_irq <= next_timer_irq;
            overflow_event <= next_overflow_event;
            ext_event_set <= next_ext_event_set;
            clock_out_pin <= next_clock_out_pin;
        end
    end

endmodule : tmr4_core

// file: verilog/tmr4_sync.sv
// Two-stage synchroniser with edge detection for the timer's pins.
// Assumes pins are asynchronous to clk; edges come out as one-cycle pulses.
`timescale 1ns/1ns
module tmr4_sync (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [tmr4_pkg::SYNC_WIDTH-1:0] pin_async,
    output logic [tmr4_pkg::SYNC_WIDTH-1:0] pin_rise,
    output logic [tmr4_pkg::SYNC_WIDTH-1:0] pin_fall
);
    logic [tmr4_pkg::SYNC_WIDTH-1:0] meta;
    logic [tmr4_pkg::SYNC_WIDTH-1:0] stable;
    logic [tmr4_pkg::SYNC_WIDTH-1:0] prev;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta <= '0;
            stable <= '0;
            prev <= '0;
        end else begin
            meta <= pin_async;
            stable <= meta;
            prev <= stable;
        end
    end

    genvar g;
    generate
        for (g = 0; g < tmr4_pkg::SYNC_WIDTH; g++) begin : g_edge
            assign pin_rise[g] = stable[g] & ~prev[g];
            assign pin_fall[g] = ~stable[g] & prev[g];
        end
    endgenerate

endmodule : tmr4_sync

// file: verilog/tmr4_tick.sv
// Count-tick selection for the high and low halves of the timer.
// Assumes all event inputs are one-cycle pulses on clk.
`timescale 1ns/1ns
module tmr4_tick (
    input wire logic clk,
    input wire logic rstn,
    input wire logic split,
    input wire logic [2:0] high_sel,
    input wire logic [1:0] low_sel,
    input wire logic pin_tick,
    input wire logic low_ovf,
    input wire tmr4_pkg::tmr4_src_s src,
    output logic tick_high,
    output logic tick_low
);
    logic [3:0] presc;
    logic [3:0] next_presc;
    logic div12;

    assign div12 = (presc == tmr4_pkg::PRESCALE_LAST);

    always_comb begin
        next_presc = div12 ? 4'h0 : presc + 4'h1;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            presc <= 4'h0;
        end else begin
            presc <= next_presc;
        end
    end

    // With the chain source selected, split operation chains the high half off the low-half overflow.
    always_comb begin
        case (high_sel)
            tmr4_pkg::HSRC_DIV12: tick_high = div12;
            tmr4_pkg::HSRC_PIN: tick_high = pin_tick;
            tmr4_pkg::HSRC_SYSCLK: tick_high = 1'b1;
            tmr4_pkg::HSRC_CHAIN: tick_high = split ? low_ovf : src.chain_in;
            tmr4_pkg::HSRC_TMR0: tick_high = src.tmr0_ovf;
            tmr4_pkg::HSRC_CMP2: tick_high = src.cmp2_event;
            tmr4_pkg::HSRC_CMP0: tick_high = src.cmp0_event;
            default: tick_high = 1'b0;
        endcase
        case (low_sel)
            tmr4_pkg::LSRC_DIV12: tick_low = div12;
            tmr4_pkg::LSRC_SYSCLK: tick_low = 1'b1;
            tmr4_pkg::LSRC_EXT: tick_low = src.chain_in;
            default: tick_low = 1'b0;
        endcase
    end

endmodule : tmr4_tick
